// File: stm_pkg.sv
// ********************************************************************
// Shared constants for the static and multicast table access path
// ********************************************************************
package stm_pkg;
	// ****************************************************************
	// Register byte addresses (word aligned)
	// ****************************************************************
	localparam logic [15:0] STM_OFS_CTRL    = 16'h041c; // Access control
	localparam logic [15:0] STM_OFS_ENTRY1  = 16'h0420; // Entry word 1
	localparam logic [15:0] STM_OFS_ENTRY2  = 16'h0424; // Entry word 2
	localparam logic [15:0] STM_OFS_ENTRY3  = 16'h0428; // Entry word 3
	localparam logic [15:0] STM_OFS_ENTRY4  = 16'h042c; // Entry word 4

	// ****************************************************************
	// Control register field positions
	// ****************************************************************
	localparam int STM_BIT_ACTION   = 0;  // 1 = read, 0 = write
	localparam int STM_BIT_SELECT   = 1;  // 1 = multicast, 0 = static
	localparam int STM_RSV_LO       = 2;  // Spare read/write bits low
	localparam int STM_RSV_HI       = 6;  // Spare read/write bits high
	localparam int STM_BIT_GO       = 7;  // Launch and done flag
	localparam int STM_IDX_LO       = 16; // Row field low bit
	localparam int STM_IDX_HI       = 21; // Row field high bit
	localparam int STM_STATIC_IDX_W = 4;  // Static table uses 19:16 only

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [5:0]  STM_RST_INDEX = 6'h00;       // Row field
	localparam logic [4:0]  STM_RST_RSV   = 5'h00;       // Spare bits
	localparam logic [31:0] STM_RST_ENTRY = 32'h00000000; // Entry words

	// ****************************************************************
	// Table memory layout
	// ****************************************************************
	localparam int          STM_MEM_DEPTH  = 80;    // 16 static + 64 multicast rows
	localparam int          STM_MEM_AW     = 7;     // Row address width
	localparam logic [6:0]  STM_MCAST_BASE = 7'h10; // First multicast row
	localparam logic [3:0]  STM_LANES_ALL  = 4'hf;  // All four entry words
	localparam logic [3:0]  STM_LANES_MC   = 4'h2;  // Entry word 2 only

	// Access sequencer states
	typedef enum logic [1:0] {
		STM_IDLE,
		STM_READ,
		STM_LOAD,
		STM_WRITE
	} stm_state_t;
endpackage : stm_pkg

// File: stm_table_mem.sv
`timescale 1ns/100ps
// ********************************************************************
// Table storage, one 128-bit row per entry, word-lane write enables
// ********************************************************************
module stm_table_mem
	import stm_pkg::*;
(
	input  wire logic                  clk_sys,  // Core clock
	input  wire logic [STM_MEM_AW-1:0] addr,     // Row address
	input  wire logic                  rd_en,    // Read strobe
	input  wire logic [3:0]            wr_lane,  // Per-word write enable
	input  wire logic [127:0]          wdata,    // Write row
	output logic      [127:0]          rdata     // Registered read row
);
	// Storage holds no reset: contents are undefined until written
	logic [127:0] mem [STM_MEM_DEPTH];

	// Write lanes independently, read into an output register
	always_ff @(posedge clk_sys) begin
		for (int l = 0; l < 4; l++) begin
			if (wr_lane[l]) begin
				mem[addr][l*32 +: 32] <= wdata[l*32 +: 32];
			end
		end
		if (rd_en) begin
			rdata <= mem[addr];
		end
	end
endmodule : stm_table_mem

// File: stm_access.sv
`timescale 1ns/100ps
module stm_access
	import stm_pkg::*;
(
	input  wire logic         clk_sys,              // Core clock
	input  wire logic         arst_n,               // Async reset, low
	input  wire logic [15:0]  reg_addr,             // Register byte address
	input  wire logic         reg_wr,               // Write strobe
	input  wire logic         reg_rd,               // Read strobe
	input  wire logic [3:0]   reg_be,               // Byte enables
	input  wire logic [31:0]  reg_wdata,            // Write data
	output logic      [31:0]  reg_rdata,            // Read data, registered
	output logic              reg_rvalid,           // Read data valid pulse
	input  wire logic         address_lookup_load,  // Lookup engine loads entries
	input  wire logic [127:0] address_lookup_entry, // Entry from lookup engine
	input  wire logic         address_lookup_search,// Lookup search running
	output logic              next_entry_clear,     // Clear next-ready pulse
	output logic              access_table_sel,     // Table the entries mean
	output logic      [127:0] entry_words           // Entry words to lookup
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge_bytes

	// Address hit on a word register
	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		return a[15:2] == ofs[15:2];
	endfunction : hit

	// ****************************************************************
	// State
	// ****************************************************************
	logic [5:0]       ctrl_index;    // Row field
	logic [4:0]       ctrl_rsv;      // Spare read/write bits
	logic             ctrl_go;       // Launch / done flag
	logic             ctrl_sel;      // Table select
	logic             ctrl_action;   // Read or write
	logic [31:0]      entry [4];     // Entry words 1..4
	stm_state_t       state;         // Sequencer state
	logic [127:0]     mem_rdata;     // Row read back
	logic [6:0]       mem_addr;      // Row address
	logic             mem_rd;        // Row read strobe
	logic [3:0]       mem_we;        // Row write lanes
	logic [31:0]      ctrl_word;     // Assembled control word
	logic             access_done;   // Access completes this cycle

	logic [5:0]       next_ctrl_index;
	logic [4:0]       next_ctrl_rsv;
	logic             next_ctrl_go;
	logic             next_ctrl_sel;
	logic             next_ctrl_action;
	logic [31:0]      next_entry [4];
	stm_state_t       next_state;
	logic [31:0]      next_reg_rdata;
	logic             next_entry_clear_v;

	// Control word as seen by software, reserved high bits read zero
	assign ctrl_word = {10'h000, ctrl_index, 8'h00, ctrl_go, ctrl_rsv,
		ctrl_sel, ctrl_action};
	assign access_table_sel = ctrl_sel;
	assign entry_words      = {entry[3], entry[2], entry[1], entry[0]};

	// ****************************************************************
	// Table memory
	// ****************************************************************
	// Row mapping: static rows first, multicast rows above them
	always_comb begin
		if (ctrl_sel) begin
			mem_addr = STM_MCAST_BASE + {1'b0, ctrl_index};
		end else begin
			mem_addr = {3'h0, ctrl_index[STM_STATIC_IDX_W-1:0]};
		end
		mem_rd = (state == STM_READ);
		if (state == STM_WRITE) begin
			mem_we = ctrl_sel ? STM_LANES_MC : STM_LANES_ALL;
		end else begin
			mem_we = 4'h0;
		end
	end

	stm_table_mem u_mem (
		.clk_sys (clk_sys),
		.addr    (mem_addr),
		.rd_en   (mem_rd),
		.wr_lane (mem_we),
		.wdata   (entry_words),
		.rdata   (mem_rdata)
	);

	// ****************************************************************
	// Access sequencer
	// ****************************************************************
	// Read takes issue plus load cycles; write finishes in one
	always_comb begin
		next_state  = state;
		access_done = 1'b0;
		case (state)
			STM_IDLE: begin
				if (ctrl_go) begin
					next_state = ctrl_action ? STM_READ : STM_WRITE;
				end
			end
			STM_READ: begin
				next_state = STM_LOAD;
			end
			STM_LOAD: begin
				next_state  = STM_IDLE;
				access_done = 1'b1;
			end
			STM_WRITE: begin
				next_state  = STM_IDLE;
				access_done = 1'b1;
			end
			default: begin
				next_state = STM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= STM_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// Control register
	// ****************************************************************
	// Writes while busy are dropped so the running access keeps its row
	always_comb begin
		logic [31:0] w;
		w                = merge_bytes(ctrl_word, reg_wdata, reg_be);
		next_ctrl_index  = ctrl_index;
		next_ctrl_rsv    = ctrl_rsv;
		next_ctrl_sel    = ctrl_sel;
		next_ctrl_action = ctrl_action;
		next_ctrl_go     = ctrl_go;
		if (access_done) begin
			next_ctrl_go = 1'b0;
		end
		if (reg_wr && hit(reg_addr, STM_OFS_CTRL) && state == STM_IDLE
			&& !ctrl_go) begin
			next_ctrl_index  = w[STM_IDX_HI:STM_IDX_LO];
			next_ctrl_rsv    = w[STM_RSV_HI:STM_RSV_LO];
			next_ctrl_sel    = w[STM_BIT_SELECT];
			next_ctrl_action = w[STM_BIT_ACTION];
			next_ctrl_go     = w[STM_BIT_GO] & reg_be[0];
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_index  <= STM_RST_INDEX;
			ctrl_rsv    <= STM_RST_RSV;
			ctrl_go     <= 1'b0;
			ctrl_sel    <= 1'b0;
			ctrl_action <= 1'b0;
		end else begin
			ctrl_index  <= next_ctrl_index;
			ctrl_rsv    <= next_ctrl_rsv;
			ctrl_go     <= next_ctrl_go;
			ctrl_sel    <= next_ctrl_sel;
			ctrl_action <= next_ctrl_action;
		end
	end

	// ****************************************************************
	// Entry registers
	// ****************************************************************
	// Priority: table read-back, then lookup engine, then software
	always_comb begin
		next_entry = entry;
		// Software word writes, byte lanes merged into the held value
		for (int i = 0; i < 4; i++) begin
			if (reg_wr && hit(reg_addr, STM_OFS_ENTRY1 + 16'(4 * i))) begin
				next_entry[i] = merge_bytes(entry[i], reg_wdata, reg_be);
			end
		end
		if (address_lookup_load) begin
			for (int i = 0; i < 4; i++) begin
				next_entry[i] = address_lookup_entry[i*32 +: 32];
			end
		end
		if (state == STM_LOAD) begin
			if (ctrl_sel) begin
				next_entry[1] = mem_rdata[63:32];
			end else begin
				for (int i = 0; i < 4; i++) begin
					next_entry[i] = mem_rdata[i*32 +: 32];
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			entry <= '{default: STM_RST_ENTRY};
		end else begin
			entry <= next_entry;
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	// Unmapped addresses read zero; data holds between reads
	always_comb begin
		if (!reg_rd) begin
			next_reg_rdata = reg_rdata;
		end else if (hit(reg_addr, STM_OFS_CTRL)) begin
			next_reg_rdata = ctrl_word;
		end else if (hit(reg_addr, STM_OFS_ENTRY1)) begin
			next_reg_rdata = entry[0];
		end else if (hit(reg_addr, STM_OFS_ENTRY2)) begin
			next_reg_rdata = entry[1];
		end else if (hit(reg_addr, STM_OFS_ENTRY3)) begin
			next_reg_rdata = entry[2];
		end else if (hit(reg_addr, STM_OFS_ENTRY4)) begin
			next_reg_rdata = entry[3];
		end else begin
			next_reg_rdata = 32'h00000000;
		end
		// Top byte of word four is the one that ends a search step
		next_entry_clear_v = reg_rd && hit(reg_addr, STM_OFS_ENTRY4) && reg_be[3]
			&& address_lookup_search;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata        <= 32'h00000000;
			reg_rvalid       <= 1'b0;
			next_entry_clear <= 1'b0;
		end else begin
			reg_rdata        <= next_reg_rdata;
			reg_rvalid       <= reg_rd;
			next_entry_clear <= next_entry_clear_v;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_read_done_time: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$rose(ctrl_go) && ctrl_action |-> ctrl_go[*3] ##1 !ctrl_go)
		else $error("read access did not finish in three cycles");
	a_write_done_time: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$rose(ctrl_go) && !ctrl_action |-> ctrl_go[*2] ##1 !ctrl_go)
		else $error("write access did not finish in two cycles");
	a_mcast_row_map: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(mem_rd || mem_we != 4'h0) && ctrl_sel |-> mem_addr == STM_MCAST_BASE + {1'b0, ctrl_index})
		else $error("multicast row address wrong");
	a_static_row_map: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(mem_rd || mem_we != 4'h0) && !ctrl_sel |-> mem_addr == {3'h0, ctrl_index[3:0]})
		else $error("static row address wrong");
	a_mcast_one_lane: assert property (@(posedge clk_sys) disable iff (!arst_n)
		mem_we != 4'h0 && ctrl_sel |-> mem_we == STM_LANES_MC)
		else $error("multicast write touched other words");
	a_mcast_keeps_word1: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state == STM_LOAD && ctrl_sel |=> entry[0] == $past(entry[0]))
		else $error("multicast read changed word one");
	a_static_load_word4: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state == STM_LOAD && !ctrl_sel |=> entry[3] == $past(mem_rdata[127:96]))
		else $error("static read did not load word four");
	a_write_only_action0: assert property (@(posedge clk_sys) disable iff (!arst_n)
		mem_we != 4'h0 |-> !ctrl_action && $past(ctrl_go))
		else $error("table write without write action");
	a_search_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_rd && hit(reg_addr, STM_OFS_ENTRY4) && reg_be[3] && address_lookup_search
		|=> next_entry_clear ##1 !next_entry_clear || $past(reg_rd))
		else $error("next-ready clear pulse missing");
	a_ctrl_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_rd && hit(reg_addr, STM_OFS_CTRL) |=> reg_rvalid && reg_rdata[31:22] == 10'h000
		&& reg_rdata[15:8] == 8'h00 && reg_rdata[7] == $past(ctrl_go))
		else $error("control readback wrong");
endmodule : stm_access

// File: stm_access_tb.sv
`timescale 1ns/100ps
// ********************************************************************
// Comparison helper: counts every compare, reports mismatches at once
// ********************************************************************
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %s exp %h got %h", n, e, g); end end

module stm_access_tb
	import stm_pkg::*;
;
	// ****************************************************************
	// Stimulus values, one per entry pattern
	// ****************************************************************
	localparam logic [127:0] PAT_A = 128'h1111_0001_2222_0002_3333_0003_4444_0004;
	localparam logic [127:0] PAT_B = 128'ha5a5_5a5a_0f0f_f0f0_dead_0bee_c001_d00d;
	localparam logic [127:0] PAT_C = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
	localparam logic [127:0] PAT_D = 128'h7777_8888_9999_aaaa_bbbb_cccc_dddd_eeee;

	logic         clk_sys;   // Core clock
	logic         arst_n;    // Async reset, low
	logic [15:0]  reg_addr;  // Register byte address
	logic         reg_wr;    // Write strobe
	logic         reg_rd;    // Read strobe
	logic [3:0]   reg_be;    // Byte enables
	logic [31:0]  reg_wdata; // Write data
	logic [31:0]  reg_rdata; // Read data
	logic         reg_rvalid;// Read valid pulse
	logic         lu_load;   // Lookup engine load pulse
	logic [127:0] lu_entry;  // Lookup engine entry
	logic         lu_search; // Lookup search level
	logic         clr_pulse; // Next-ready clear pulse
	logic         tbl_sel;   // Table the entries mean
	logic [127:0] ent_words; // Entry words out
	logic         clr_seen;  // Clear pulse seen with last read
	logic [31:0]  rv;        // Scratch read value
	int           bad_count; // Mismatches
	int           cmp_count; // Comparisons made

	stm_access DUT (
		.clk_sys              (clk_sys),
		.arst_n               (arst_n),
		.reg_addr             (reg_addr),
		.reg_wr               (reg_wr),
		.reg_rd               (reg_rd),
		.reg_be               (reg_be),
		.reg_wdata            (reg_wdata),
		.reg_rdata            (reg_rdata),
		.reg_rvalid           (reg_rvalid),
		.address_lookup_load  (lu_load),
		.address_lookup_entry (lu_entry),
		.address_lookup_search(lu_search),
		.next_entry_clear     (clr_pulse),
		.access_table_sel     (tbl_sel),
		.entry_words          (ent_words)
	);

	// 100 MHz core clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ****************************************************************
	// Register port tasks
	// ****************************************************************
	task automatic tally_and_finish();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// One-cycle write strobe, held until the taking edge
	task automatic wr(input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_be    <= be;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	// Data and the clear pulse are looked at in the one cycle they stand
	task automatic rd(input logic [15:0] a, input logic [3:0] be, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_be   <= be;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		`CHK("rvalid", 1'b1, reg_rvalid)
		d = reg_rdata;
		clr_seen = clr_pulse;
	endtask : rd

	task automatic rdchk(input string n, input logic [15:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, 4'hf, v);
		`CHK(n, e, v)
	endtask : rdchk

	// Bounded poll of the go flag; control must read back with go cleared
	task automatic wait_done(input logic [31:0] c);
		logic [31:0] v;
		for (int i = 0; i < 20; i++) begin
			rd(STM_OFS_CTRL, 4'hf, v);
			if (v[STM_BIT_GO] === 1'b0) break;
		end
		if (v[STM_BIT_GO] !== 1'b0) begin
			bad_count++;
			$display("BAD go_done exp 0 got %h", v);
			tally_and_finish();
		end
		`CHK("ctrl_done", c & 32'h003f007f, v)
	endtask : wait_done

	task automatic run(input logic [31:0] c);
		wr(STM_OFS_CTRL, 4'hf, c);
		wait_done(c);
	endtask : run

	function automatic logic [31:0] ctl(input logic s, input logic r, input logic [5:0] idx);
		return {10'h000, idx, 8'h00, 1'b1, 5'h00, s, r};
	endfunction : ctl

	task automatic put(input logic [127:0] e);
		for (int i = 0; i < 4; i++) wr(STM_OFS_ENTRY1 + 16'(4 * i), 4'hf, e[32 * i +: 32]);
	endtask : put

	task automatic expect_entries(input logic [127:0] e);
		for (int i = 0; i < 4; i++) rdchk("entry", STM_OFS_ENTRY1 + 16'(4 * i), e[32 * i +: 32]);
		`CHK("entry_words", e, ent_words)
	endtask : expect_entries

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{reg_addr, reg_wr, reg_rd, reg_be, reg_wdata} = '0;
		{lu_load, lu_entry, lu_search} = '0;
		bad_count = 0;
		cmp_count = 0;
		arst_n = 1'b0;
		repeat (20) @(posedge clk_sys);
		arst_n <= 1'b1;
		// Reset values and map, including a hole just past the last word
		rdchk("ctrl", STM_OFS_CTRL, 32'h0);
		expect_entries(128'h0);
		rdchk("unmapped", 16'h0430, 32'h0);
		// Read-only holes stay zero, spare bits store, no launch
		wr(STM_OFS_CTRL, 4'hf, 32'hffffff7e);
		rdchk("ctrl_rsv", STM_OFS_CTRL, 32'h003f007e);
		`CHK("sel", 1'b1, tbl_sel)
		wr(STM_OFS_CTRL, 4'hf, 32'h0);
		// Go without byte lane 0 must not launch
		wr(STM_OFS_CTRL, 4'he, 32'h000000ff);
		rdchk("ctrl_be", STM_OFS_CTRL, 32'h0);
		// Static rows: index bits 21:20 ignored, so 0x15 lands on row 5
		put(PAT_A);
		run(ctl(1'b0, 1'b0, 6'h15));
		put(PAT_B);
		run(ctl(1'b0, 1'b0, 6'h06));
		put(PAT_C);
		run(ctl(1'b0, 1'b1, 6'h05));
		expect_entries(PAT_A);
		// Busy control write dropped: row 6 is read, not row 5
		wr(STM_OFS_CTRL, 4'hf, ctl(1'b0, 1'b1, 6'h06));
		wr(STM_OFS_CTRL, 4'hf, ctl(1'b0, 1'b1, 6'h05));
		wait_done(ctl(1'b0, 1'b1, 6'h06));
		expect_entries(PAT_B);
		// Multicast rows carry word 2 only
		put(PAT_C);
		run(ctl(1'b1, 1'b0, 6'h25));
		`CHK("sel_mc", 1'b1, tbl_sel)
		put(PAT_D);
		run(ctl(1'b1, 1'b1, 6'h25));
		expect_entries({PAT_D[127:64], PAT_C[63:32], PAT_D[31:0]});
		// Multicast row 5 is a different place from static row 5
		run(ctl(1'b1, 1'b0, 6'h05));
		run(ctl(1'b0, 1'b1, 6'h05));
		`CHK("sel_st", 1'b0, tbl_sel)
		expect_entries(PAT_A);
		// Lookup engine shares the entry words
		@(posedge clk_sys);
		lu_load  <= 1'b1;
		lu_entry <= PAT_D;
		@(posedge clk_sys);
		lu_load <= 1'b0;
		expect_entries(PAT_D);
		// Clear pulse only for a word 4 read with byte lane 3 enabled during search
		@(posedge clk_sys);
		lu_search <= 1'b1;
		rd(STM_OFS_ENTRY4, 4'hf, rv);
		`CHK("clr_hit", 1'b1, clr_seen)
		rd(STM_OFS_ENTRY4, 4'h7, rv);
		`CHK("clr_lane", 1'b0, clr_seen)
		rd(STM_OFS_ENTRY3, 4'hf, rv);
		`CHK("clr_word", 1'b0, clr_seen)
		@(posedge clk_sys);
		lu_search <= 1'b0;
		rd(STM_OFS_ENTRY4, 4'hf, rv);
		`CHK("clr_idle", 1'b0, clr_seen)
		// Second reset in mid-run clears control and entry registers again
		@(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		rdchk("ctrl_rst", STM_OFS_CTRL, 32'h0);
		expect_entries(128'h0);
		tally_and_finish();
	end

	// Watchdog: a hang counts as a mismatch
	initial begin
		repeat (50000) @(posedge clk_sys);
		bad_count++;
		tally_and_finish();
	end
endmodule : stm_access_tb
